// ===== rtl/tpec_pkg.sv
// package for the transactional performance event counting block
package tpec_pkg;
	localparam int NUM_CNT = 4;
	localparam int CNT_W = 32;
	localparam int ACC_W = 32;
	localparam logic [31:0] ACC_MAX = 32'hFFFFFFFF;

	// event selections
	typedef enum logic [3:0] {
		EV_NONE, EV_TXN_FAILED, EV_COMMITTED_INSTR, EV_COMMITTED_CYCLES,
		EV_FAIL_CANCEL, EV_FAIL_ERROR, EV_FAIL_IMPL, EV_FAIL_CONFLICT,
		EV_FAIL_DEPTH, EV_FAIL_CAPACITY, EV_FAIL_REMOTE_INVAL,
		EV_FAIL_WSET_EVICT
	} tpec_event_t;

	// failure cause codes
	typedef enum logic [2:0] {
		CAUSE_CANCEL, CAUSE_ERROR, CAUSE_IMPL, CAUSE_CONFLICT,
		CAUSE_DEPTH, CAUSE_CAPACITY, CAUSE_OTHER
	} tpec_cause_t;

	// per-cycle pipeline report
	typedef struct packed {
		logic        in_txn;
		logic        thread_active;
		logic        clock_halted;
		logic [1:0]  retired;
		logic        commit;
		logic        fail;
		tpec_cause_t cause;
		logic        remote_inval;
		logic        wset_evict;
	} tpec_pipe_t;

	// AXI4-Lite register map
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_OVF      = 8'h04;
	localparam logic [7:0] REG_IRQ_EN   = 8'h08;
	localparam logic [7:0] REG_CFG_BASE = 8'h10;
	localparam logic [7:0] REG_CNT_BASE = 8'h20;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;
	localparam int CFG_FILT_BIT = 4;
endpackage : tpec_pkg

// ===== rtl/tpec_top.sv
// transactional performance event counters with AXI4-Lite registers
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - failed-transaction event counts every failed or cancelled transaction.
// - filter bit set: failure events still count, since failure ends a transaction.
// - committed-instructions counts retirements in transactions that commit.
// - per-transaction increment saturates at two to the 32 minus one.
// - commit-dependent counts accumulate separately, added only on commit.
// - committed-cycles counts each transactional cycle of committing transactions.
// - committed-cycles stops while the clock is halted by wait instructions.
// - committed-cycles counts only cycles with this thread active.
// - cancel-cause counter counts cancellation failures.
// - error-cause counter counts error failures.
// - implementation-cause counter counts implementation-specific failures.
// - conflict counter counts memory-conflict failures.
// - depth counter counts nesting-limit failures.
// - capacity counter counts every size-cause failure.
// - remote-invalidation counter counts implementation failures from remote invalidation.
// - write-set eviction counter counts size failures from write-set eviction.
// - other events overflow in transactions exactly as outside them.
// - commit-dependent counters leave overflow unset when a transaction fails.
// - commit-dependent counters raise no overflow interrupt inside a transaction.
// - deferred: status and interrupt only when the commit update overflows.
// - filter bit set: counting is unchanged; the bit is only stored and read back.
module tpec_top
	import tpec_pkg::*;
#(
	parameter int N = NUM_CNT
) (
	// clock and reset
	input  wire logic             CLOCK_IN,
	input  wire logic             RESET_N_IN,
	// pipeline report
	input  var  tpec_pkg::tpec_pipe_t PIPE_IN,
	// axi4-lite write
	input  wire logic [7:0]       AWADDR_IN,
	input  wire logic             AWVALID_IN,
	output logic                  AWREADY_OUT,
	input  wire logic [31:0]      WDATA_IN,
	input  wire logic [3:0]       WSTRB_IN,
	input  wire logic             WVALID_IN,
	output logic                  WREADY_OUT,
	output logic [1:0]            BRESP_OUT,
	output logic                  BVALID_OUT,
	input  wire logic             BREADY_IN,
	// axi4-lite read
	input  wire logic [7:0]       ARADDR_IN,
	input  wire logic             ARVALID_IN,
	output logic                  ARREADY_OUT,
	output logic [31:0]           RDATA_OUT,
	output logic [1:0]            RRESP_OUT,
	output logic                  RVALID_OUT,
	input  wire logic             RREADY_IN,
	// overflow interrupt request
	output logic                  OVF_IRQ_OUT
);
	import tpec_pkg::*;

	logic              en_q, en_d;
	logic [N-1:0]      ovf_q, ovf_d;
	logic [N-1:0]      irq_en_q, irq_en_d;
	logic [N-1:0]      filt_q, filt_d;
	tpec_event_t       sel_q [N];
	tpec_event_t       sel_d [N];
	logic [CNT_W-1:0]  cnt_q [N];
	logic [CNT_W-1:0]  cnt_d [N];
	logic [ACC_W-1:0]  acc_q [N];
	logic [ACC_W-1:0]  acc_d [N];
	logic              irq_q, irq_d;
	tpec_pipe_t        p;

	logic              aw_ok_q, aw_ok_d, w_ok_q, w_ok_d;
	logic [7:0]        awa_q, awa_d;
	logic [31:0]       wd_q, wd_d;
	logic [3:0]        ws_q, ws_d;
	logic              bv_q, bv_d, rv_q, rv_d;
	logic [1:0]        br_q, br_d, rr_q, rr_d;
	logic [31:0]       rd_q, rd_d;
	// ready outputs kept in their own flops
	logic              aw_rdy_q, aw_rdy_d;
	logic              w_rdy_q, w_rdy_d;
	logic              ar_rdy_q, ar_rdy_d;

	// event selected and eligible this cycle
	function automatic logic fail_hit(tpec_event_t s, tpec_pipe_t r);
		logic h;
		h = 1'b0;
		if (r.fail) begin
			unique case (s)
				EV_TXN_FAILED:        h = 1'b1;
				EV_FAIL_CANCEL:       h = r.cause == CAUSE_CANCEL;
				EV_FAIL_ERROR:        h = r.cause == CAUSE_ERROR;
				EV_FAIL_IMPL:         h = r.cause == CAUSE_IMPL;
				EV_FAIL_CONFLICT:     h = r.cause == CAUSE_CONFLICT;
				EV_FAIL_DEPTH:        h = r.cause == CAUSE_DEPTH;
				EV_FAIL_CAPACITY:     h = r.cause == CAUSE_CAPACITY;
				EV_FAIL_REMOTE_INVAL: h = r.cause == CAUSE_IMPL && r.remote_inval;
				EV_FAIL_WSET_EVICT:   h = r.cause == CAUSE_CAPACITY && r.wset_evict;
				default:              h = 1'b0;
			endcase
		end
		return h;
	endfunction : fail_hit

	// register index decode
	function automatic logic [7:0] reg_idx(logic [7:0] a, logic [7:0] base);
		return (a - base) >> 2;
	endfunction : reg_idx

	assign p = PIPE_IN;

	// counting datapath
	always_comb begin
		logic [ACC_W:0] sum;
		logic [CNT_W:0] tot;
		logic [1:0]     inc;
		sum = '0;
		tot = '0;
		inc = '0;
		ovf_d = ovf_q;
		irq_d = irq_q;
		// software clear first, so a hardware set in the same cycle wins
		if (aw_ok_q && w_ok_q && !bv_q && awa_q == REG_OVF && ws_q[0])
			ovf_d = ovf_q & ~wd_q[N-1:0];
		for (int i = 0; i < N; i++) begin
			cnt_d[i] = cnt_q[i];
			acc_d[i] = acc_q[i];
			if (en_q && (sel_q[i] == EV_COMMITTED_INSTR ||
			    sel_q[i] == EV_COMMITTED_CYCLES)) begin
				inc = '0;
				if (p.in_txn && sel_q[i] == EV_COMMITTED_INSTR)
					inc = p.retired;
				if (p.in_txn && sel_q[i] == EV_COMMITTED_CYCLES &&
				    p.thread_active && !p.clock_halted)
					inc = 2'h1;
				sum = {1'b0, acc_q[i]} + {{(ACC_W-1){1'b0}}, inc};
				if (sum[ACC_W])
					sum = {1'b0, ACC_MAX};
				if (p.commit) begin
					tot = {1'b0, cnt_q[i]} + {1'b0, sum[ACC_W-1:0]};
					cnt_d[i] = tot[CNT_W-1:0];
					acc_d[i] = '0;
					if (tot[CNT_W]) begin
						ovf_d[i] = 1'b1;
						if (irq_en_q[i])
							irq_d = 1'b1;
					end
				end else if (p.fail) begin
					acc_d[i] = '0;
				end else begin
					acc_d[i] = sum[ACC_W-1:0];
				end
			end else if (en_q && sel_q[i] != EV_NONE) begin
				// failure events ignore the filter, as failure leaves the state
				if (fail_hit(sel_q[i], p)) begin
					tot = {1'b0, cnt_q[i]} + 33'h000000001;
					cnt_d[i] = tot[CNT_W-1:0];
					if (tot[CNT_W]) begin
						ovf_d[i] = 1'b1;
						if (irq_en_q[i])
							irq_d = 1'b1;
					end
				end
			end
		end
		if (!(|(ovf_d & irq_en_q)))
			irq_d = 1'b0;
		// software writes
		if (aw_ok_q && w_ok_q && !bv_q) begin
			for (int i = 0; i < N; i++) begin
				if (awa_q == REG_CNT_BASE + 8'(4 * i) && &ws_q) begin
					cnt_d[i] = wd_q;
					acc_d[i] = '0;
				end
			end
		end
	end

	// configuration writes and bus handshake
	always_comb begin
		logic [7:0] k;
		en_d = en_q;
		irq_en_d = irq_en_q;
		filt_d = filt_q;
		sel_d = sel_q;
		aw_ok_d = aw_ok_q;
		w_ok_d = w_ok_q;
		awa_d = awa_q;
		wd_d = wd_q;
		ws_d = ws_q;
		bv_d = bv_q;
		br_d = br_q;
		rv_d = rv_q;
		rr_d = rr_q;
		rd_d = rd_q;
		k = '0;
		if (AWVALID_IN && !aw_ok_q) begin
			aw_ok_d = 1'b1;
			awa_d = {AWADDR_IN[7:2], 2'h0};
		end
		if (WVALID_IN && !w_ok_q) begin
			w_ok_d = 1'b1;
			wd_d = WDATA_IN;
			ws_d = WSTRB_IN;
		end
		if (aw_ok_q && w_ok_q && !bv_q) begin
			bv_d = 1'b1;
			br_d = RESP_SLVERR;
			k = reg_idx(awa_q, REG_CFG_BASE);
			if (awa_q == REG_CTRL || awa_q == REG_OVF ||
			    awa_q == REG_IRQ_EN)
				br_d = RESP_OKAY;
			if (awa_q == REG_CTRL && ws_q[0])
				en_d = wd_q[0];
			if (awa_q == REG_IRQ_EN && ws_q[0])
				irq_en_d = wd_q[N-1:0];
			if (awa_q >= REG_CFG_BASE && k < 8'(N)) begin
				br_d = RESP_OKAY;
				if (ws_q[0]) begin
					sel_d[k[1:0]] = tpec_event_t'(wd_q[3:0]);
					filt_d[k[1:0]] = wd_q[CFG_FILT_BIT];
				end
			end
			k = reg_idx(awa_q, REG_CNT_BASE);
			if (awa_q >= REG_CNT_BASE && k < 8'(N))
				br_d = RESP_OKAY;
		end
		if (bv_q && BREADY_IN) begin
			bv_d = 1'b0;
			aw_ok_d = 1'b0;
			w_ok_d = 1'b0;
		end
		if (ARVALID_IN && !rv_q) begin
			rv_d = 1'b1;
			rr_d = RESP_OKAY;
			rd_d = '0;
			k = reg_idx({ARADDR_IN[7:2], 2'h0}, REG_CFG_BASE);
			if ({ARADDR_IN[7:2], 2'h0} == REG_CTRL)
				rd_d = {31'h0, en_q};
			else if ({ARADDR_IN[7:2], 2'h0} == REG_OVF)
				rd_d[N-1:0] = ovf_q;
			else if ({ARADDR_IN[7:2], 2'h0} == REG_IRQ_EN)
				rd_d[N-1:0] = irq_en_q;
			else if (ARADDR_IN >= REG_CFG_BASE && k < 8'(N))
				rd_d = {27'h0, filt_q[k[1:0]], sel_q[k[1:0]]};
			else begin
				k = reg_idx({ARADDR_IN[7:2], 2'h0}, REG_CNT_BASE);
				if (ARADDR_IN >= REG_CNT_BASE && k < 8'(N))
					rd_d = cnt_q[k[1:0]];
				else
					rr_d = RESP_SLVERR;
			end
		end else if (rv_q && RREADY_IN) begin
			rv_d = 1'b0;
		end
		// readies follow the capture state of the next cycle
		aw_rdy_d = !aw_ok_d;
		w_rdy_d  = !w_ok_d;
		ar_rdy_d = !rv_d;
	end

	always_ff @(posedge CLOCK_IN) begin
		if (!RESET_N_IN) begin
			en_q <= 1'b0;
			ovf_q <= '0;
			irq_en_q <= '0;
			filt_q <= '0;
			irq_q <= 1'b0;
			aw_ok_q <= 1'b0;
			w_ok_q <= 1'b0;
			awa_q <= '0;
			wd_q <= '0;
			ws_q <= '0;
			bv_q <= 1'b0;
			br_q <= RESP_OKAY;
			rv_q <= 1'b0;
			rr_q <= RESP_OKAY;
			rd_q <= '0;
			aw_rdy_q <= 1'b1;
			w_rdy_q <= 1'b1;
			ar_rdy_q <= 1'b1;
			for (int i = 0; i < N; i++) begin
				sel_q[i] <= EV_NONE;
				cnt_q[i] <= '0;
				acc_q[i] <= '0;
			end
		end else begin
			en_q <= en_d;
			ovf_q <= ovf_d;
			irq_en_q <= irq_en_d;
			filt_q <= filt_d;
			irq_q <= irq_d;
			aw_ok_q <= aw_ok_d;
			w_ok_q <= w_ok_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			ws_q <= ws_d;
			bv_q <= bv_d;
			br_q <= br_d;
			rv_q <= rv_d;
			rr_q <= rr_d;
			rd_q <= rd_d;
			aw_rdy_q <= aw_rdy_d;
			w_rdy_q <= w_rdy_d;
			ar_rdy_q <= ar_rdy_d;
			sel_q <= sel_d;
			cnt_q <= cnt_d;
			acc_q <= acc_d;
		end
	end

	always_comb begin
		AWREADY_OUT = aw_rdy_q;
		WREADY_OUT  = w_rdy_q;
		BVALID_OUT  = bv_q;
		BRESP_OUT   = br_q;
		ARREADY_OUT = ar_rdy_q;
		RVALID_OUT  = rv_q;
		RRESP_OUT   = rr_q;
		RDATA_OUT   = rd_q;
		OVF_IRQ_OUT = irq_q;
	end
endmodule : tpec_top
`default_nettype wire

// ===== tb/tpec_monitor.sv
// checker on the ports of the transactional event counter block
`timescale 1ns/1ps
`default_nettype none
module tpec_monitor
	import tpec_pkg::*;
(
	// clock, reset and pipeline report
	input wire logic CLOCK_IN, RESET_N_IN,
	input var tpec_pkg::tpec_pipe_t PIPE_IN,
	// register bus and interrupt
	input wire logic AWVALID_IN, AWREADY_OUT, WVALID_IN, WREADY_OUT,
	input wire logic BVALID_OUT, BREADY_IN, ARVALID_IN, ARREADY_OUT,
	input wire logic RVALID_OUT, RREADY_IN, OVF_IRQ_OUT,
	input wire logic [31:0] RDATA_OUT
);
	logic [2:0] since_q, since_d;
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!RESET_N_IN);
	// cycles since the last commit, failure or register write
	always_comb begin
		since_d = (since_q == 3'h7) ? since_q : since_q + 3'h1;
		if (PIPE_IN.commit || PIPE_IN.fail || (WVALID_IN && WREADY_OUT))
			since_d = 3'h0;
	end
	always_ff @(posedge CLOCK_IN) begin
		since_q <= !RESET_N_IN ? 3'h7 : since_d;
	end
	property p_aw_hold; AWVALID_IN && AWREADY_OUT |=> !AWREADY_OUT; endproperty
	a_aw_hold: assert property (p_aw_hold) else $error("address taken twice");
	property p_w_hold; WVALID_IN && WREADY_OUT |=> !WREADY_OUT; endproperty
	a_w_hold: assert property (p_w_hold) else $error("data taken twice");
	property p_b_lat;
		AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT |-> ##[1:2] BVALID_OUT;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write response late");
	property p_b_stand; BVALID_OUT && !BREADY_IN |=> BVALID_OUT; endproperty
	a_b_stand: assert property (p_b_stand) else $error("write response lost");
	property p_b_drop; BVALID_OUT && BREADY_IN |=> !BVALID_OUT; endproperty
	a_b_drop: assert property (p_b_drop) else $error("write response repeated");
	property p_r_lat; ARVALID_IN && ARREADY_OUT |=> RVALID_OUT; endproperty
	a_r_lat: assert property (p_r_lat) else $error("read data late");
	property p_r_stand;
		RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT);
	endproperty
	a_r_stand: assert property (p_r_stand) else $error("read data changed");
	property p_ar_block; RVALID_OUT |-> !ARREADY_OUT; endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken early");
	property p_irq_cause; $rose(OVF_IRQ_OUT) |-> since_q <= 3'h6; endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq no cause");
	c_commit: cover property (PIPE_IN.commit);
	c_fail: cover property (PIPE_IN.fail);
	c_irq: cover property ($rose(OVF_IRQ_OUT));
endmodule : tpec_monitor
bind tpec_top tpec_monitor tpec_monitor_i (.CLOCK_IN(CLOCK_IN),
	.RESET_N_IN(RESET_N_IN), .PIPE_IN(PIPE_IN), .AWVALID_IN(AWVALID_IN),
	.AWREADY_OUT(AWREADY_OUT), .WVALID_IN(WVALID_IN), .WREADY_OUT(WREADY_OUT),
	.BVALID_OUT(BVALID_OUT), .BREADY_IN(BREADY_IN), .ARVALID_IN(ARVALID_IN),
	.ARREADY_OUT(ARREADY_OUT), .RVALID_OUT(RVALID_OUT), .RREADY_IN(RREADY_IN),
	.OVF_IRQ_OUT(OVF_IRQ_OUT), .RDATA_OUT(RDATA_OUT));
`default_nettype wire

// ===== tb/tpec_pipe_model.sv
// pipeline partner that reports transactions to the counters
`timescale 1ns/1ps
`default_nettype none
module tpec_pipe_model
	import tpec_pkg::*;
(
	input wire logic clk_in,
	output var tpec_pkg::tpec_pipe_t pipe_out
);
	localparam tpec_pipe_t IDLE = '{1'b0, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0,
		CAUSE_OTHER, 1'b0, 1'b0};
	initial pipe_out = IDLE;
	// cycle 1 thread idle, cycle 2 clock halted, last cycle ends it
	task automatic run(input int n, input logic [1:0] r, input logic ok,
		input tpec_cause_t c, input logic rv, input logic ws);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_in);
			pipe_out.in_txn <= 1'b1;
			pipe_out.thread_active <= (i != 1);
			pipe_out.clock_halted <= (i == 2);
			pipe_out.retired <= (i == 1 || i == 2) ? 2'h0 : r;
			pipe_out.commit <= ok && i == n - 1;
			pipe_out.fail <= !ok && i == n - 1;
			pipe_out.cause <= c;
			pipe_out.remote_inval <= rv;
			pipe_out.wset_evict <= ws;
		end
		@(posedge clk_in);
		pipe_out <= IDLE;
	endtask : run
endmodule : tpec_pipe_model
`default_nettype wire

// ===== tb/tb_tpec_top.sv
// self-checking bench for the transactional event counters
`timescale 1ns/1ps
`default_nettype none
module tb_tpec_top;
	import tpec_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, irq;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid;
	tpec_pipe_t pipe;
	int n_errors = 0, cmp_count = 0;
	always #2 clk = ~clk;
	tpec_top tpec_top_i (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .PIPE_IN(pipe),
		.AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
		.WDATA_IN(wdata), .WSTRB_IN(4'hF), .WVALID_IN(wvalid),
		.WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
		.BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
		.ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
		.RVALID_OUT(rvalid), .RREADY_IN(rready), .OVF_IRQ_OUT(irq));
	tpec_pipe_model tpec_pipe_model_i (.clk_in(clk), .pipe_out(pipe));
	function automatic logic [7:0] cfg(int i); return REG_CFG_BASE + 8'(4 * i);
	endfunction : cfg
	function automatic logic [7:0] cnt(int i); return REG_CNT_BASE + 8'(4 * i);
	endfunction : cnt
	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
		int t;
		logic ha, hw, hb, sv;
		t = 0;
		@(posedge clk);
		{awvalid, wvalid, arvalid} <= {we, we, !we};
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		do begin
			@(negedge clk);
			ha = (awvalid && awready) || (arvalid && arready);
			hw = wvalid && wready;
			hb = (bready && bvalid) || (rready && rvalid);
			sv = bvalid || rvalid;
			q = rdata;
			r = we ? bresp : rresp;
			@(posedge clk);
			if (ha) {awvalid, arvalid} <= 2'b00;
			if (hw) wvalid <= 1'b0;
			if (hb) {bready, rready} <= 2'b00;
			else if (sv) {bready, rready} <= {we, !we};
			t++;
		end while (!hb && t < 200);
		chk("bus answer", 32'h1, {31'h0, hb});
	endtask : bus
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		logic [1:0] r;
		bus(1'b0, a, 32'h0, q, r);
		chk(nm, e, q);
	endtask : rchk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic [1:0] r;
		bus(1'b1, a, d, q, r);
		chk("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
	endtask : wr
	task automatic ichk(input string nm, input logic e);
		@(negedge clk);
		chk(nm, {31'h0, e}, {31'h0, irq});
	endtask : ichk
	task automatic txn(input int n, input logic ok, input tpec_cause_t c,
		input logic [1:0] qf);
		tpec_pipe_model_i.run(n, 2'h3, ok, c, qf[1], qf[0]);
	endtask : txn
	task automatic t_regs();
		logic [31:0] q;
		logic [1:0] r;
		rchk("ctrl reset", REG_CTRL, 32'h0);
		rchk("count reset", cnt(0), 32'h0);
		bus(1'b0, 8'hF0, 32'h0, q, r);
		chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
		chk("unmapped data", 32'h0, q);
		wr(REG_CTRL, 32'h1);
		$display("regs done");
	endtask : t_regs
	task automatic t_causes();
		logic [31:0] ex [12] = '{32'h0, 32'h8, 32'h0, 32'h0, 32'h1, 32'h1,
			32'h2, 32'h1, 32'h1, 32'h2, 32'h1, 32'h1};
		tpec_cause_t cs [8] = '{CAUSE_CANCEL, CAUSE_ERROR, CAUSE_IMPL,
			CAUSE_CONFLICT, CAUSE_DEPTH, CAUSE_CAPACITY, CAUSE_IMPL, CAUSE_CAPACITY};
		logic [1:0] qs [8] = '{2'h0, 2'h0, 2'h2, 2'h0, 2'h0, 2'h1, 2'h0,
			2'h0};
		for (int g = 0; g < 3; g++) begin
			for (int i = 0; i < 4; i++) begin
				wr(cfg(i), 32'(4 * g + i) | 32'(g % 2) << CFG_FILT_BIT);
				wr(cnt(i), 32'h0);
			end
			for (int k = 0; k < 8; k++) txn(3, 1'b0, cs[k], qs[k]);
			for (int i = 0; i < 4; i++)
				rchk("fails", cnt(i), ex[4 * g + i]);
		end
		$display("causes done");
	endtask : t_causes
	task automatic t_commit();
		wr(cfg(0), 32'h2);
		wr(cfg(1), 32'h3);
		wr(cnt(0), 32'h0);
		wr(cnt(1), 32'h0);
		txn(10, 1'b1, CAUSE_OTHER, 2'b00);
		rchk("instr", cnt(0), 32'(3 * 8));
		rchk("cycles", cnt(1), 32'h8);
		txn(10, 1'b0, CAUSE_CONFLICT, 2'b00);
		rchk("instr fail", cnt(0), 32'(3 * 8));
		rchk("cycles fail", cnt(1), 32'h8);
		$display("commit done");
	endtask : t_commit
	task automatic t_ovf();
		wr(cfg(1), 32'h1);
		wr(cnt(0), 32'hFFFFFFFE);
		wr(cnt(1), 32'hFFFFFFFF);
		wr(REG_IRQ_EN, 32'h1);
		wr(REG_OVF, 32'hF);
		txn(6, 1'b0, CAUSE_ERROR, 2'b00);
		rchk("instr kept", cnt(0), 32'hFFFFFFFE);
		rchk("flags fail", REG_OVF, 32'h2);
		ichk("irq fail", 1'b0);
		txn(6, 1'b1, CAUSE_OTHER, 2'b00);
		rchk("instr wrap", cnt(0), 32'h0000000A);
		rchk("flags commit", REG_OVF, 32'h3);
		ichk("irq commit", 1'b1);
		wr(REG_OVF, 32'h1);
		rchk("flags clear", REG_OVF, 32'h2);
		ichk("irq clear", 1'b0);
		$display("overflow done");
	endtask : t_ovf
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_causes();
		t_commit();
		t_ovf();
		final_report();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		final_report();
	end
endmodule : tb_tpec_top
`default_nettype wire
